/* hw/ufb_pkg.sv */
// Constants and types shared by the serial flash boot command block
package ufb_pkg;

  // Command codes
  localparam logic [7:0] CMD_PAGE_READ = 8'hff;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
  localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
  localparam logic [7:0] CMD_ERASE_OK = 8'hd0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_ID_CHECK = 8'hf5;
  localparam logic [7:0] CMD_DOWNLOAD = 8'hfa;
  localparam logic [7:0] CMD_VERSION = 8'hfb;
  localparam logic [7:0] CMD_BOOT_READ = 8'hfc;
  localparam logic [7:0] CMD_BAUD_9600 = 8'hb0;
  localparam logic [7:0] CMD_BAUD_57600 = 8'hb3;

  // Rate detection
  localparam int SYNC_BYTES = 16;
  localparam int SYNC_HALF = 8;
  localparam int ZERO_LOW_BITS = 9;
  localparam int RUN_W = 18;
  localparam int DIV_W = 16;
  localparam int DIV_57600 = 6;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0010;

  // Serial frame
  localparam logic [3:0] STOP_SLOT = 4'h9;

  // Transfer lengths
  localparam int PAGE_BYTES = 256;
  localparam logic [15:0] PAGE_LAST = 16'(PAGE_BYTES - 1);
  localparam int VER_BYTES = 8;
  localparam int STATUS_BYTES = 2;
  localparam int FIFO_DEPTH = 4;

  // Version text, value is arbitrary
  localparam logic [63:0] VERSION_TEXT = 64'h5645_5231_2e30_3020;

  // Status layout
  localparam int READY_BIT = 7;
  localparam int ERASE_FAIL_BIT = 5;
  localparam int PROG_FAIL_BIT = 4;
  localparam int SEC_BOOT_BIT = 7;
  localparam int SEC_CKS_BIT = 4;
  localparam int SEC_ID_LO = 2;
  localparam logic [1:0] ID_VERIFIED = 2'h3;

  // Rate selection, low two bits of the rate command
  typedef enum logic [1:0] {
    BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600
  } ufb_baud_t;

  // Command sequencer states
  typedef enum logic [3:0] {
    S_DETECT, S_IDLE, S_ARG, S_RD_REQ, S_RD_WAIT, S_PUSH,
    S_REPLY, S_PROG, S_BUSY, S_DATA, S_BAUD
  } ufb_state_t;

endpackage

/* hw/ufb_fifo.sv */
// Small valid/ready byte FIFO in front of the transmitter
`timescale 1ns/1ps
module ufb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [PW-1:0] wr_ptr_ff;       // Next write slot
  logic [PW-1:0] rd_ptr_ff;       // Next read slot
  logic [PW:0] count_ff;          // Words held
  logic push;
  logic pop;

  assign o_in_ready = count_ff != (PW+1)'(DEPTH);
  assign o_out_valid = count_ff != '0;
  assign o_out_data = mem[rd_ptr_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Storage write, no reset needed on data
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

/* hw/ufb_boot_cmd.sv */
// Serial flash boot command interpreter with rate detection
`timescale 1ns/1ps
module ufb_boot_cmd
  import ufb_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Serial link
  input wire logic i_serial_receive_pin,
  output logic o_txd,
  output logic o_busy_output_pin,
  // Flash access
  output logic o_flash_rd,
  output logic o_flash_boot,
  output logic [23:0] o_flash_addr,
  input wire logic [7:0] i_flash_rdata,
  input wire logic i_flash_rvalid,
  output logic o_flash_wr,
  output logic [7:0] o_flash_wdata,
  output logic o_flash_prog,
  output logic o_flash_erase,
  input wire logic i_flash_done,
  input wire logic i_flash_fail,
  input wire logic i_flash_blank,
  input wire logic [7:0] i_lock_data,
  // Identity check result
  input wire logic [1:0] i_id_state,
  // Download and ID byte streams
  output logic o_ram_valid,
  output logic o_id_valid,
  output logic [7:0] o_stream_data,
  output logic o_exec,
  // Link status
  output logic o_linked,
  output logic [1:0] o_baud_sel
);

  // Sequencer
  ufb_state_t state_ff;
  logic [7:0] cmd_ff;            // Current command code
  logic [7:0] arg_ff [4];        // Argument bytes after the code
  logic [15:0] cnt_ff;           // Byte counter
  logic [7:0] sum_ff;            // Download data sum
  logic [7:0] rd_data_ff;        // Byte fetched from flash

  // Rate detection
  logic rxd_q_ff;                // Receive level one cycle ago
  logic [RUN_W-1:0] run_ff;      // Current low run length
  logic [RUN_W-1:0] min_ff;      // Shortest run, first half
  logic [RUN_W-1:0] max_ff;      // Longest run, second half
  logic [4:0] sync_ff;           // Zero bytes measured
  logic [DIV_W-1:0] base_ff;     // Cycles per bit at 9600
  logic [DIV_W-1:0] div_ff;      // Cycles per bit in use

  // Receiver
  logic rx_on_ff;
  logic [DIV_W-1:0] rx_tmr_ff;
  logic [3:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_vld_ff;               // One-cycle byte strobe

  // Transmitter
  logic tx_on_ff;
  logic [DIV_W-1:0] tx_tmr_ff;
  logic [3:0] tx_bit_ff;
  logic [8:0] tx_sh_ff;

  // Status flags
  logic erase_fail_ff;
  logic prog_fail_ff;
  logic boot_done_ff;
  logic cks_ok_ff;

  // Combinational helpers
  logic det_done;
  logic [RUN_W-1:0] max_nxt;
  logic [RUN_W:0] run_sum;
  logic [RUN_W:0] base_calc;
  logic [DIV_W-1:0] base_new;
  logic allowed;
  logic open_cmd;
  logic [15:0] arg_need;
  logic arg_last;
  logic clr_ev;
  logic fail_ev;
  logic dl_end;
  logic reply_last;
  logic [7:0] reply_byte;
  logic [7:0] primary_status_byte;
  logic [7:0] secondary_status_byte;
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_in_data;
  logic f_out_valid;
  logic [7:0] f_out_data;
  logic tx_idle;
  logic rate_apply;

  // Detection ends on the rising edge after the sixteenth zero byte
  assign det_done = state_ff == S_DETECT && i_serial_receive_pin &&
                    !rxd_q_ff && run_ff != '0 &&
                    sync_ff == 5'(SYNC_BYTES - 1);
  assign max_nxt = (run_ff > max_ff) ? run_ff : max_ff;
  // Average of fastest and slowest run, over the low bits of a zero
  assign run_sum = {1'b0, min_ff} + {1'b0, max_nxt};
  assign base_calc = run_sum / (RUN_W+1)'(2 * ZERO_LOW_BITS);
  assign base_new = base_calc[DIV_W-1:0];

  // Commands open before the ID is verified
  assign open_cmd = rx_sh_ff == CMD_READ_STATUS ||
                    rx_sh_ff == CMD_ID_CHECK || rx_sh_ff == CMD_VERSION ||
                    rx_sh_ff[7:2] == CMD_BAUD_9600[7:2];
  assign allowed = open_cmd || i_id_state == ID_VERIFIED ||
                   i_flash_blank;

  // Argument bytes each command takes after its code
  always_comb begin
    arg_need = 16'h0000;
    unique case (cmd_ff)
      CMD_PAGE_READ, CMD_PAGE_PROG, CMD_LOCK_READ, CMD_BOOT_READ: begin
        arg_need = 16'h0002;
      end
      CMD_DOWNLOAD: begin
        arg_need = 16'h0003;
      end
      CMD_ERASE_ALL: begin
        arg_need = 16'h0001;
      end
      CMD_ID_CHECK: begin
        arg_need = 16'h0004;
      end
      default: begin
        arg_need = 16'h0001;
      end
    endcase
  end

  assign arg_last = state_ff == S_ARG && rx_vld_ff &&
                    cnt_ff == arg_need - 16'h0001;
  assign clr_ev = state_ff == S_IDLE && rx_vld_ff && allowed &&
                  rx_sh_ff == CMD_CLEAR_STATUS;
  assign fail_ev = state_ff == S_BUSY && i_flash_done && i_flash_fail;
  assign dl_end = state_ff == S_DATA && cnt_ff == 16'h0000 &&
                  cmd_ff == CMD_DOWNLOAD;

  // Status bytes as seen by a status read
  always_comb begin
    primary_status_byte = 8'h00;
    primary_status_byte[READY_BIT] = !o_busy_output_pin;
    primary_status_byte[ERASE_FAIL_BIT] = erase_fail_ff;
    primary_status_byte[PROG_FAIL_BIT] = prog_fail_ff;
    secondary_status_byte = 8'h00;
    secondary_status_byte[SEC_BOOT_BIT] = boot_done_ff;
    secondary_status_byte[SEC_CKS_BIT] = cks_ok_ff;
    secondary_status_byte[SEC_ID_LO+1:SEC_ID_LO] = i_id_state;
  end

  // Byte to queue for short answers
  always_comb begin
    reply_byte = cmd_ff;
    reply_last = cnt_ff == 16'h0000;
    unique case (cmd_ff)
      CMD_READ_STATUS: begin
        reply_byte = (cnt_ff == 16'h0000) ? primary_status_byte
                                          : secondary_status_byte;
        reply_last = cnt_ff == 16'(STATUS_BYTES - 1);
      end
      CMD_VERSION: begin
        reply_byte = VERSION_TEXT[(VER_BYTES - 1 -
                                   int'(cnt_ff[2:0])) * 8 +: 8];
        reply_last = cnt_ff == 16'(VER_BYTES - 1);
      end
      CMD_LOCK_READ: begin
        reply_byte = i_lock_data;
      end
      default: begin
        reply_byte = cmd_ff;
      end
    endcase
  end

  // FIFO feed: flash page bytes or short answers
  assign f_in_valid = state_ff == S_PUSH || state_ff == S_REPLY;
  assign f_in_data = (state_ff == S_PUSH) ? rd_data_ff : reply_byte;
  assign tx_idle = !tx_on_ff && !f_out_valid;
  assign rate_apply = state_ff == S_BAUD && tx_idle;

  // Command sequencer
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= S_DETECT;
      cmd_ff <= 8'h00;
      cnt_ff <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        arg_ff[i] <= 8'h00;
      end
    end else begin
      unique case (state_ff)
        S_DETECT: begin
          if (det_done) begin
            cmd_ff <= CMD_BAUD_9600;
            cnt_ff <= 16'h0000;
            state_ff <= S_REPLY;
          end
        end
        S_IDLE: begin
          cnt_ff <= 16'h0000;
          if (rx_vld_ff && allowed) begin
            cmd_ff <= rx_sh_ff;
            case (rx_sh_ff) inside
              CMD_PAGE_READ, CMD_PAGE_PROG, CMD_LOCK_READ, CMD_BOOT_READ,
              CMD_DOWNLOAD, CMD_ERASE_ALL, CMD_ID_CHECK: begin
                state_ff <= S_ARG;
              end
              CMD_READ_STATUS, CMD_VERSION,
              [CMD_BAUD_9600:CMD_BAUD_57600]: begin
                state_ff <= S_REPLY;
              end
              default: begin
                state_ff <= S_IDLE;
              end
            endcase
          end
        end
        S_ARG: begin
          if (rx_vld_ff) begin
            arg_ff[cnt_ff[1:0]] <= rx_sh_ff;
            cnt_ff <= cnt_ff + 16'h0001;
          end
          if (arg_last) begin
            cnt_ff <= 16'h0000;
            unique case (cmd_ff)
              CMD_PAGE_READ, CMD_BOOT_READ: begin
                state_ff <= S_RD_REQ;
              end
              CMD_PAGE_PROG: begin
                state_ff <= S_PROG;
              end
              CMD_LOCK_READ: begin
                state_ff <= S_REPLY;
              end
              CMD_ERASE_ALL: begin
                state_ff <= (rx_sh_ff == CMD_ERASE_OK) ? S_BUSY
                                                       : S_IDLE;
              end
              CMD_DOWNLOAD: begin
                cnt_ff <= {arg_ff[1], arg_ff[0]};
                state_ff <= S_DATA;
              end
              default: begin
                cnt_ff <= {8'h00, rx_sh_ff};
                state_ff <= S_DATA;
              end
            endcase
          end
        end
        S_RD_REQ: begin
          state_ff <= S_RD_WAIT;
        end
        S_RD_WAIT: begin
          if (i_flash_rvalid) begin
            state_ff <= S_PUSH;
          end
        end
        S_PUSH: begin
          // Stalls here while the transmit FIFO is full
          if (f_in_ready) begin
            if (cnt_ff == PAGE_LAST) begin
              state_ff <= S_IDLE;
            end else begin
              cnt_ff <= cnt_ff + 16'h0001;
              state_ff <= S_RD_REQ;
            end
          end
        end
        S_REPLY: begin
          if (f_in_ready) begin
            cnt_ff <= cnt_ff + 16'h0001;
            if (reply_last) begin
              cnt_ff <= 16'h0000;
              state_ff <= (cmd_ff[7:2] == CMD_BAUD_9600[7:2]) ? S_BAUD
                                                              : S_IDLE;
            end
          end
        end
        S_PROG: begin
          if (rx_vld_ff) begin
            cnt_ff <= cnt_ff + 16'h0001;
            if (cnt_ff == PAGE_LAST) begin
              state_ff <= S_BUSY;
            end
          end
        end
        S_BUSY: begin
          if (i_flash_done) begin
            state_ff <= S_IDLE;
          end
        end
        S_DATA: begin
          if (cnt_ff == 16'h0000) begin
            state_ff <= S_IDLE;
          end else if (rx_vld_ff) begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        S_BAUD: begin
          if (rate_apply) begin
            state_ff <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Low-run measurement of the sixteen zero bytes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxd_q_ff <= 1'b1;
      run_ff <= '0;
      min_ff <= '1;
      max_ff <= '0;
      sync_ff <= 5'h00;
    end else if (state_ff == S_DETECT) begin
      rxd_q_ff <= i_serial_receive_pin;
      if (!i_serial_receive_pin && run_ff != '1) begin
        run_ff <= run_ff + 1'b1;
      end
      if (i_serial_receive_pin && !rxd_q_ff && run_ff != '0) begin
        run_ff <= '0;
        sync_ff <= sync_ff + 5'h01;
        if (sync_ff < 5'(SYNC_HALF)) begin
          min_ff <= (run_ff < min_ff) ? run_ff : min_ff;
        end else begin
          max_ff <= max_nxt;
        end
      end
    end
  end

  // Bit period: detected base, then the selected rate.
  // The programmer must pick a rate the clock can reach.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_ff <= DIV_RESET;
      div_ff <= DIV_RESET;
      o_baud_sel <= BAUD_9600;
      o_linked <= 1'b0;
    end else if (det_done) begin
      base_ff <= base_new;
      div_ff <= base_new;
      o_linked <= 1'b1;
    end else if (rate_apply) begin
      o_baud_sel <= cmd_ff[1:0];
      unique case (ufb_baud_t'(cmd_ff[1:0]))
        BAUD_9600: div_ff <= base_ff;
        BAUD_19200: div_ff <= base_ff >> 1;
        BAUD_38400: div_ff <= base_ff >> 2;
        BAUD_57600: div_ff <= base_ff / DIV_W'(DIV_57600);
      endcase
    end
  end

  // Receiver: 8 data bits LSB first, one stop bit, no parity
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_on_ff <= 1'b0;
      rx_tmr_ff <= '0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_vld_ff <= 1'b0;
    end else begin
      rx_vld_ff <= 1'b0;
      if (!rx_on_ff) begin
        // Start bit seen, aim at mid-bit
        if (state_ff != S_DETECT && !i_serial_receive_pin) begin
          rx_on_ff <= 1'b1;
          rx_tmr_ff <= div_ff >> 1;
          rx_bit_ff <= 4'h0;
        end
      end else if (rx_tmr_ff != '0) begin
        rx_tmr_ff <= rx_tmr_ff - 1'b1;
      end else begin
        rx_tmr_ff <= div_ff - 1'b1;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0 && i_serial_receive_pin) begin
          rx_on_ff <= 1'b0;  // False start
        end else if (rx_bit_ff == STOP_SLOT) begin
          rx_on_ff <= 1'b0;
          rx_vld_ff <= i_serial_receive_pin;
        end else if (rx_bit_ff != 4'h0) begin
          rx_sh_ff <= {i_serial_receive_pin, rx_sh_ff[7:1]};
        end
      end
    end
  end

  // Transmit queue
  ufb_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data(f_in_data),
    .o_out_valid(f_out_valid),
    .i_out_ready(!tx_on_ff),
    .o_out_data(f_out_data)
  );

  // Transmitter: start bit, 8 data bits LSB first, stop bit
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_on_ff <= 1'b0;
      tx_tmr_ff <= '0;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 9'h1ff;
      o_txd <= 1'b1;
    end else if (!tx_on_ff) begin
      o_txd <= 1'b1;
      if (f_out_valid) begin
        tx_on_ff <= 1'b1;
        o_txd <= 1'b0;
        tx_sh_ff <= {1'b1, f_out_data};
        tx_tmr_ff <= div_ff - 1'b1;
        tx_bit_ff <= 4'h0;
      end
    end else if (tx_tmr_ff != '0) begin
      tx_tmr_ff <= tx_tmr_ff - 1'b1;
    end else begin
      tx_tmr_ff <= div_ff - 1'b1;
      tx_bit_ff <= tx_bit_ff + 4'h1;
      if (tx_bit_ff == STOP_SLOT) begin
        tx_on_ff <= 1'b0;
      end else begin
        o_txd <= tx_sh_ff[0];
        tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
      end
    end
  end

  // Flash requests; address follows page and byte counter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flash_rd <= 1'b0;
      o_flash_boot <= 1'b0;
      o_flash_addr <= 24'h00_0000;
      o_flash_wr <= 1'b0;
      o_flash_wdata <= 8'h00;
      o_flash_prog <= 1'b0;
      o_flash_erase <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      o_flash_addr <= {arg_ff[1], arg_ff[0], cnt_ff[7:0]};
      o_flash_rd <= state_ff == S_RD_REQ;
      o_flash_boot <= cmd_ff == CMD_BOOT_READ;
      o_flash_wr <= state_ff == S_PROG && rx_vld_ff;
      o_flash_wdata <= rx_sh_ff;
      o_flash_prog <= state_ff == S_PROG && rx_vld_ff &&
                      cnt_ff == PAGE_LAST;
      o_flash_erase <= arg_last && cmd_ff == CMD_ERASE_ALL &&
                       rx_sh_ff == CMD_ERASE_OK;
      if (state_ff == S_RD_WAIT && i_flash_rvalid) begin
        rd_data_ff <= i_flash_rdata;
      end
    end
  end

  // Busy pin: high during erase or program, one cycle for clear
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy_output_pin <= 1'b0;
    end else begin
      o_busy_output_pin <= clr_ev ||
        (arg_last && cmd_ff == CMD_ERASE_ALL &&
         rx_sh_ff == CMD_ERASE_OK) ||
        (state_ff == S_PROG && rx_vld_ff && cnt_ff == PAGE_LAST) ||
        (state_ff == S_BUSY && !i_flash_done);
    end
  end

  // Sticky status flags; a new event wins over a clear
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      erase_fail_ff <= 1'b0;
      prog_fail_ff <= 1'b0;
      boot_done_ff <= 1'b0;
      cks_ok_ff <= 1'b0;
    end else begin
      erase_fail_ff <= (erase_fail_ff && !clr_ev) ||
                       (fail_ev && cmd_ff == CMD_ERASE_ALL);
      prog_fail_ff <= (prog_fail_ff && !clr_ev) ||
                      (fail_ev && cmd_ff == CMD_PAGE_PROG);
      boot_done_ff <= (boot_done_ff && !clr_ev) || dl_end;
      if (dl_end) begin
        cks_ok_ff <= sum_ff == arg_ff[2];
      end else if (clr_ev) begin
        cks_ok_ff <= 1'b0;
      end
    end
  end

  // Download and ID byte streams with running sum
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_ff <= 8'h00;
      o_ram_valid <= 1'b0;
      o_id_valid <= 1'b0;
      o_stream_data <= 8'h00;
      o_exec <= 1'b0;
    end else begin
      o_ram_valid <= state_ff == S_DATA && rx_vld_ff &&
                     cnt_ff != 16'h0000 && cmd_ff == CMD_DOWNLOAD;
      o_id_valid <= state_ff == S_DATA && rx_vld_ff &&
                    cnt_ff != 16'h0000 && cmd_ff == CMD_ID_CHECK;
      o_stream_data <= rx_sh_ff;
      o_exec <= dl_end && sum_ff == arg_ff[2];
      if (state_ff == S_ARG) begin
        sum_ff <= 8'h00;
      end else if (state_ff == S_DATA && rx_vld_ff) begin
        sum_ff <= sum_ff + rx_sh_ff;
      end
    end
  end

endmodule

/* test/ufb_prog_model.sv */
// Serial programmer model: byte sender and byte receiver
`timescale 1ns/1ps
module ufb_prog_model (
  // Link
  input wire logic i_clock,
  input wire logic i_txd,
  output logic o_rxd
);
  int bit_cycles = 16; // Receive bit period in clocks
  logic [7:0] rxq[$]; // Bytes heard from the device
  logic [7:0] rx_b; // Byte being assembled
  initial o_rxd = 1'b1;
  // Start, eight bits LSB first, stop, one idle bit
  task automatic send(input logic [7:0] b, input int p);
    for (int i = -1; i < 10; i++) begin
      @(posedge i_clock);
      o_rxd <= (i < 0) ? 1'b0 : (i < 8) ? b[i] : 1'b1;
      repeat (p - 1) @(posedge i_clock);
    end
  endtask
  // Frame receiver sampling mid-bit
  always begin
    @(negedge i_txd);
    repeat (bit_cycles / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles) @(posedge i_clock);
      rx_b[i] = i_txd;
    end
    repeat (bit_cycles) @(posedge i_clock);
    rxq.push_back(rx_b);
  end
endmodule

/* test/ufb_boot_cmd_asserts.sv */
// Port assertions for the boot command block
`timescale 1ns/1ps
module ufb_boot_cmd_chk
  import ufb_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Watched ports
  input wire logic o_txd,
  input wire logic o_busy_output_pin,
  input wire logic o_flash_rd,
  input wire logic o_flash_wr,
  input wire logic o_flash_erase,
  input wire logic [23:0] o_flash_addr,
  input wire logic i_flash_done,
  input wire logic i_flash_blank,
  input wire logic [1:0] i_id_state,
  input wire logic o_linked,
  input wire logic [1:0] o_baud_sel
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [23:0] last_ff; // Previous read address
  // Remember the last flash read address
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_ff <= 24'h00_0000;
    end else if (o_flash_rd) begin
      last_ff <= o_flash_addr;
    end
  end
  property p_lock; o_linked |=> o_linked; endproperty
  a_lock: assert property (p_lock) else $error("link lost");
  property p_quiet;
    !o_linked |-> !(o_flash_rd || o_flash_wr || o_flash_erase);
  endproperty
  a_quiet: assert property (p_quiet) else $error("early access");
  property p_gate; i_id_state != ID_VERIFIED && !i_flash_blank
    |-> !(o_flash_rd || o_flash_wr || o_flash_erase); endproperty
  a_gate: assert property (p_gate) else $error("locked access");
  property p_up; o_flash_rd && o_flash_addr[7:0] != 8'h00
    |-> o_flash_addr == last_ff + 24'h00_0001; endproperty
  a_up: assert property (p_up) else $error("read order");
  property p_er; o_flash_erase |-> ##[0:2] o_busy_output_pin; endproperty
  a_er: assert property (p_er) else $error("erase busy");
  property p_done;
    o_busy_output_pin && i_flash_done |=> !o_busy_output_pin;
  endproperty
  a_done: assert property (p_done) else $error("busy stuck");
  property p_idle; !o_linked |-> o_txd; endproperty
  a_idle: assert property (p_idle) else $error("tx not idle");
  property p_rate; $changed(o_baud_sel) |-> o_txd && $past(o_txd); endproperty
  a_rate: assert property (p_rate) else $error("rate in frame");
endmodule
bind ufb_boot_cmd ufb_boot_cmd_chk chk_u (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .o_txd(o_txd), .o_busy_output_pin(o_busy_output_pin),
  .o_flash_rd(o_flash_rd), .o_flash_wr(o_flash_wr),
  .o_flash_erase(o_flash_erase), .o_flash_addr(o_flash_addr),
  .i_flash_done(i_flash_done), .i_flash_blank(i_flash_blank),
  .i_id_state(i_id_state), .o_linked(o_linked), .o_baud_sel(o_baud_sel));

/* test/ufb_boot_cmd_tb_top.sv */
// Testbench for the serial boot command block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module ufb_boot_cmd_tb_top;
  import ufb_pkg::*;
  logic i_clock = 0, i_rst_n = 0, rxd, txd, busy, rd, er, lk;
  logic done = 0, blank = 0, rv = 0, wr, pg, rmv, xq;
  logic [1:0] id = 0, bsel;
  logic [7:0] rdat = 0, b, dl = 0;
  logic [23:0] addr, rd_addr;
  int miscompares = 0, check_count = 0, rd_cnt = 0, busy_cnt = 0;
  int wr_cnt = 0, x_cnt = 0, rm_cnt = 0;
  always #12.5 i_clock = ~i_clock;
  ufb_prog_model prog_u (.i_clock(i_clock), .i_txd(txd), .o_rxd(rxd));
  ufb_boot_cmd dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_serial_receive_pin(rxd), .o_txd(txd), .o_busy_output_pin(busy),
    .o_flash_rd(rd), .o_flash_boot(), .o_flash_addr(addr),
    .i_flash_rdata(rdat), .i_flash_rvalid(rv), .o_flash_wr(wr),
    .o_flash_wdata(), .o_flash_prog(pg), .o_flash_erase(er),
    .i_flash_done(done), .i_flash_fail(1'b1), .i_flash_blank(blank),
    .i_lock_data(8'hff), .i_id_state(id), .o_ram_valid(rmv), .o_id_valid(),
    .o_stream_data(), .o_exec(xq), .o_linked(lk), .o_baud_sel(bsel));
  // Flash stand-in: next-cycle read data, late failing erase or program
  always @(posedge i_clock) begin
    rv <= rd;
    rdat <= addr[7:0] ^ 8'h5a;
    dl <= {dl[6:0], er || pg};
    if (wr) wr_cnt <= wr_cnt + 1;
    if (xq) x_cnt <= x_cnt + 1;
    if (rmv) rm_cnt <= rm_cnt + 1;
    done <= dl[7];
    if (rd && rd_cnt == 0) rd_addr <= addr;
    if (rd) rd_cnt <= rd_cnt + 1;
    if (busy) busy_cnt <= busy_cnt + 1;
  end
  task automatic tx(input logic [7:0] v);
    prog_u.send(v, prog_u.bit_cycles);
  endtask
  // Wait for one reply byte and compare it
  task automatic ex(input string n, input logic [7:0] e);
    int k;
    k = 0;
    while (prog_u.rxq.size() == 0 && k < 9000) begin
      @(posedge i_clock);
      k++;
    end
    b = (prog_u.rxq.size() > 0) ? prog_u.rxq.pop_front() : 8'hxx;
    `CHK(n, e, b)
  endtask
  task automatic cmd3(input logic [7:0] c);
    tx(c);
    tx(8'h12);
    tx(8'h34);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #2_500_000;
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    for (int i = 0; i < 16; i++) begin
      prog_u.send(8'h00, (i < 8) ? 12 + (i % 2) * 4 : 19 + i % 2);
    end
    ex("check", 8'hb0);
    `CHK("linked", 1'b1, lk)
    tx(CMD_READ_STATUS);
    ex("srd", 8'h80);
    ex("secondary_status_byte", 8'h00);
    cmd3(CMD_PAGE_READ);
    repeat (400) @(posedge i_clock);
    `CHK("locked reads", 0, rd_cnt)
    tx(CMD_VERSION);
    for (int i = 0; i < VER_BYTES; i++) begin
      ex("ver", VERSION_TEXT[63 - 8 * i -: 8]);
    end
    @(posedge i_clock) blank <= 1'b1;
    tx(CMD_ERASE_ALL);
    tx(CMD_ERASE_OK);
    repeat (60) @(posedge i_clock);
    tx(CMD_READ_STATUS);
    ex("srd fail", 8'ha0);
    ex("secondary_status_byte", 8'h00);
    busy_cnt = 0;
    tx(CMD_CLEAR_STATUS);
    tx(CMD_READ_STATUS);
    ex("srd clr", 8'h80);
    ex("secondary_status_byte", 8'h00);
    `CHK("busy", 1, busy_cnt)
    @(posedge i_clock);
    blank <= 1'b0;
    id <= ID_VERIFIED;
    rd_cnt = 0;
    cmd3(CMD_PAGE_READ);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      ex("page", 8'(i) ^ 8'h5a);
    end
    `CHK("page addr", 24'h34_1200, rd_addr)
    `CHK("reads", PAGE_BYTES, rd_cnt)
    tx(8'hb1);
    ex("echo", 8'hb1);
    prog_u.bit_cycles = 8;
    repeat (200) @(posedge i_clock);
    `CHK("rate", BAUD_19200, bsel)
    tx(CMD_READ_STATUS);
    ex("srd fast", 8'h80);
    ex("secondary_status_byte id", 8'h0c);
    cmd3(CMD_LOCK_READ);
    ex("lock", 8'hff);
    cmd3(CMD_PAGE_PROG);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      tx(8'(i));
    end
    tx(CMD_DOWNLOAD);
    tx(8'h02);
    tx(8'h00);
    tx(8'h03);
    tx(8'h01);
    tx(8'h02);
    tx(8'h12);
    tx(CMD_READ_STATUS);
    ex("srd prog", 8'h90);
    ex("secondary_status_byte boot", 8'h9c);
    `CHK("writes", PAGE_BYTES, wr_cnt)
    `CHK("ram", 2, rm_cnt)
    `CHK("exec", 1, x_cnt)
    finish_test();
  end
endmodule
